/* File: dio_pkg.sv */
// Purpose: shared constants for the 24-line digital I/O port
// Assumes: 20 MHz reference clock
// Notes: register map is a local choice; see the top module
package dio_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] REG_PORT_A = 4'h0;
  localparam logic [3:0] REG_PORT_B = 4'h1;
  localparam logic [3:0] REG_PORT_C = 4'h2;
  localparam logic [3:0] REG_DIR_CTRL = 4'h3;
  localparam logic [3:0] REG_BUF_CTRL = 4'h4;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_CNT_LO = 4'h7;
  localparam logic [3:0] REG_CNT_HI = 4'h8;
  localparam logic [3:0] REG_CNT_RELOAD_LO = 4'h9;
  localparam logic [3:0] REG_CNT_RELOAD_HI = 4'ha;
  // Direction control fields: a one means input
  localparam int DIR_A_BIT = 4;
  localparam int DIR_C_HI_BIT = 3;
  localparam int DIR_B_BIT = 1;
  localparam int DIR_C_LO_BIT = 0;
  localparam int DIR_MODE_SET_BIT = 7;
  // Buffer control and interrupt fields
  localparam int BUF_EN_BIT = 0;
  localparam int IRQ_DIG_BIT = 0;
  localparam int IRQ_TMR_BIT = 1;
  localparam int PORT_C_BIT_THREE = 3;
  // Reset values: everything input, buffers off
  localparam logic [7:0] DIR_CTRL_RST = 8'h9b;
  localparam logic [7:0] BUF_CTRL_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // Counter tick: 1 MHz from 20 MHz
  localparam int REF_CLK_HZ = 20000000;
  localparam int CNT_CLK_HZ = 1000000;
  localparam int CNT_DIV = REF_CLK_HZ / CNT_CLK_HZ;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RELOAD_RST = 16'hffff;
endpackage

/* File: dio_tick_if.sv */
// Purpose: ties the counter tick source to the counter
// Assumes: one clock domain
// Notes: tick is a one-cycle pulse standing for the falling 1 MHz edge
`timescale 1ns/1ps
interface dio_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

/* File: dio_tick_gen.sv */
// Purpose: 1 MHz counting tick from the reference clock
// Assumes: CNT_DIV of at least 2
// Notes: tick marks the falling edge of the modelled counter clock
`timescale 1ns/1ps
module dio_tick_gen (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Tick out
  dio_tick_if.src tk
);
  import dio_pkg::*;
  typedef struct packed {
    logic [4:0] div;
    logic tick;
  } tick_st_t;
  tick_st_t st_r;
  tick_st_t st_nxt;
  localparam logic [4:0] DIV_LAST = 5'(CNT_DIV - 1);
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.div == DIV_LAST) begin
      st_nxt.div = 5'h00;
      st_nxt.tick = 1'b1; // R12
    end else begin
      st_nxt.div = st_r.div + 5'h01;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tk.tick = st_r.tick;
endmodule // dio_tick_gen

/* File: dio_counter.sv */
// Purpose: one 16-bit down counter, output high on terminal count
// Assumes: tick from dio_tick_gen
// Notes: square-wave-free simple rate mode; output pulses one tick wide
`timescale 1ns/1ps
module dio_counter (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic [15:0] i_reload,
  input wire logic i_load,
  dio_tick_if.dst tk,
  // Status
  output logic [15:0] o_count,
  output logic o_out
);
  import dio_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic out;
  } cnt_st_t;
  cnt_st_t st_r;
  cnt_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (i_load) begin
      st_nxt.cnt = i_reload;
      st_nxt.out = 1'b0;
    end else if (tk.tick) begin // R12
      if (st_r.cnt == 16'h0001) begin
        st_nxt.cnt = i_reload;
        st_nxt.out = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
        st_nxt.out = 1'b0;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= {CNT_RELOAD_RST, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_count = st_r.cnt;
  assign o_out = st_r.out;
endmodule // dio_counter

/* File: dio_port.sv */
// Purpose: 24-line digital I/O port with direction-steered buffers and interrupts
// Assumes: field lines and jumpers are asynchronous, pass two flip-flops
// Notes: one timer counter modelled; further counter groups not built
//
// Operation
// R1: Three byte ports A, B, C, each direction set independently by software.
// R2: Port C upper and lower nibbles have separate direction settings.
// R3: Buffer drive direction follows the direction control register automatically.
// R4: In program-control buffer position, a control bit enables or tristates buffers.
// R5: In always-on buffer position, buffers stay enabled regardless of control bit.
// R6: After reset no line driven until software initialises the port.
// R7: Port position and digital jumper: interrupt on rising edge of port C bit three.
// R8: External position: interrupt on rising edge of external interrupt input.
// R9: Low interrupt-disable input suppresses digital and external interrupt requests.
// R10: Timer jumper fitted: interrupt from counter two output of first group.
// R11: Optional sixteen-bit counter groups for counting and timing.
// R12: Counters clock from one megahertz tick, counting on its falling edge.
// R13: Jumpers are static inputs sampled continuously by the logic.
`timescale 1ns/1ps
module dio_port (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [dio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dio_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dio_pkg::DATA_W-1:0] o_rdata,
  // Field lines
  input wire logic [23:0] i_line,
  output logic [23:0] o_line,
  output logic [23:0] o_line_oe,
  // External interrupt pins
  input wire logic i_ext_irq,
  input wire logic i_irq_disable_n,
  // Jumpers
  input wire logic i_buffers_always_on_position,
  input wire logic i_external_source_position,
  input wire logic i_digital_irq_enable_jumper,
  input wire logic i_timer_irq_enable_jumper,
  // Interrupt
  output logic o_irq
);
  import dio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [23:0] line_s1;
    logic [23:0] line_s2;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic edge_prev;
    logic tmr_prev;
    logic [23:0] out_data;
    logic [7:0] dir_ctrl;
    logic [7:0] buf_ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [15:0] reload;
    logic [7:0] reload_lo_hold;
    logic cnt_load;
    logic [7:0] rdata;
    logic [23:0] line_o;
    logic [23:0] line_oe;
    logic irq;
  } port_st_t;
  port_st_t st_r;
  port_st_t st_nxt;

  logic [15:0] cnt_value;
  logic cnt_out;

  dio_tick_if tk_if ();

  dio_tick_gen u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .tk(tk_if.src)
  );

  // Counter two of the first group; the other counters are not modelled
  dio_counter u_cnt2 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_reload(st_r.reload),
    .i_load(st_r.cnt_load),
    .tk(tk_if.dst),
    .o_count(cnt_value),
    .o_out(cnt_out)
  ); // R10 R11

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [23:0] line_drive(input logic [7:0] dir);
    logic [23:0] d;
    d = '0;
    d[7:0] = {8{~dir[DIR_A_BIT]}}; // R1
    d[15:8] = {8{~dir[DIR_B_BIT]}};
    d[19:16] = {4{~dir[DIR_C_LO_BIT]}}; // R2
    d[23:20] = {4{~dir[DIR_C_HI_BIT]}};
    return d;
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] dir_mask, input logic [7:0] outv,
                                           input logic [7:0] inv);
    return (dir_mask & outv) | (~dir_mask & inv);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic [23:0] drive;
  logic buf_on;
  logic dig_src;
  logic dig_rise;
  logic tmr_rise;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic ext_s;
  logic dis_n_s;
  logic jp_on_s;
  logic jp_ext_s;
  logic jp_dig_s;
  logic jp_tmr_s;

  always_comb begin
    st_nxt = st_r;
    st_nxt.line_s1 = i_line;
    st_nxt.line_s2 = st_r.line_s1;
    st_nxt.pin_s1 = {i_ext_irq, i_irq_disable_n, i_buffers_always_on_position,
                     i_external_source_position, i_digital_irq_enable_jumper,
                     i_timer_irq_enable_jumper}; // R13
    st_nxt.pin_s2 = st_r.pin_s1;
    {ext_s, dis_n_s, jp_on_s, jp_ext_s, jp_dig_s, jp_tmr_s} = st_r.pin_s2;
    st_nxt.cnt_load = 1'b0;
    st_nxt.rdata = 8'h00;

    // Interrupt source select and edge detect
    dig_src = jp_ext_s ? ext_s : st_r.line_s2[16 + PORT_C_BIT_THREE]; // R7 R8
    st_nxt.edge_prev = dig_src;
    dig_rise = dig_src & ~st_r.edge_prev & jp_dig_s & dis_n_s; // R9
    st_nxt.tmr_prev = cnt_out;
    tmr_rise = cnt_out & ~st_r.tmr_prev & jp_tmr_s; // R10
    irq_set = '0;
    irq_set[IRQ_DIG_BIT] = dig_rise;
    irq_set[IRQ_TMR_BIT] = tmr_rise;
    irq_clr = '0;

    if (i_wr) begin
      case (i_addr)
        REG_PORT_A: st_nxt.out_data[7:0] = i_wdata;
        REG_PORT_B: st_nxt.out_data[15:8] = i_wdata;
        REG_PORT_C: st_nxt.out_data[23:16] = i_wdata;
        REG_DIR_CTRL: begin
          if (i_wdata[DIR_MODE_SET_BIT]) begin
            st_nxt.dir_ctrl = i_wdata;
            st_nxt.out_data = '0; // Mode set clears outputs like a classic PERIPHERAL_INTERFACE_CHIP
          end else begin
            // Bit set/reset of a port C line
            st_nxt.out_data[16 + i_wdata[3:1]] = i_wdata[0];
          end
        end
        REG_BUF_CTRL: st_nxt.buf_ctrl = i_wdata;
        REG_IRQ_STATUS: irq_clr = i_wdata[1:0];
        REG_IRQ_MASK: st_nxt.irq_mask = i_wdata[1:0];
        REG_CNT_RELOAD_LO: st_nxt.reload_lo_hold = i_wdata;
        REG_CNT_RELOAD_HI: begin
          st_nxt.reload = {i_wdata, st_r.reload_lo_hold};
          st_nxt.cnt_load = 1'b1;
        end
        default: ;
      endcase
    end

    // Set wins over a same-cycle clear
    st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;

    if (i_rd) begin
      case (i_addr)
        REG_PORT_A: st_nxt.rdata = port_read(st_r.line_oe[7:0], st_r.out_data[7:0], st_r.line_s2[7:0]);
        REG_PORT_B: st_nxt.rdata = port_read(st_r.line_oe[15:8], st_r.out_data[15:8],
                                             st_r.line_s2[15:8]);
        REG_PORT_C: st_nxt.rdata = port_read(st_r.line_oe[23:16], st_r.out_data[23:16],
                                             st_r.line_s2[23:16]);
        REG_DIR_CTRL: st_nxt.rdata = st_r.dir_ctrl;
        REG_BUF_CTRL: st_nxt.rdata = st_r.buf_ctrl;
        REG_IRQ_STATUS: st_nxt.rdata = {6'h00, st_r.irq_status};
        REG_IRQ_MASK: st_nxt.rdata = {6'h00, st_r.irq_mask};
        REG_CNT_LO: st_nxt.rdata = cnt_value[7:0];
        REG_CNT_HI: st_nxt.rdata = cnt_value[15:8];
        REG_CNT_RELOAD_LO: st_nxt.rdata = st_r.reload[7:0];
        REG_CNT_RELOAD_HI: st_nxt.rdata = st_r.reload[15:8];
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // Buffer drive: direction from control register, gated by buffer mode
    buf_on = jp_on_s | st_r.buf_ctrl[BUF_EN_BIT]; // R4 R5
    drive = line_drive(st_r.dir_ctrl) & {24{buf_on}}; // R3 R6
    st_nxt.line_oe = drive;
    st_nxt.line_o = st_r.out_data & drive;
    st_nxt.irq = |(st_r.irq_status & st_r.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      // Pulled-up lines idle high; avoids a false rising edge after reset
      st_r.line_s1 <= '1;
      st_r.line_s2 <= '1;
      st_r.edge_prev <= 1'b1; // R7
      st_r.dir_ctrl <= DIR_CTRL_RST; // R6
      st_r.buf_ctrl <= BUF_CTRL_RST;
      st_r.irq_mask <= IRQ_MASK_RST;
      st_r.reload <= CNT_RELOAD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_line = st_r.line_o;
  assign o_line_oe = st_r.line_oe;
  assign o_irq = st_r.irq;
endmodule // dio_port

/* File: dio_port_props.sv */
// Purpose: port-level checks for dio_port
// Assumes: one clock, async active-low reset
// Notes: bound into every dio_port instance
`timescale 1ns/1ps
module dio_port_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [dio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dio_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [dio_pkg::DATA_W-1:0] o_rdata,
  // Lines, jumper, interrupt
  input wire logic [23:0] o_line,
  input wire logic [23:0] o_line_oe,
  input wire logic i_buffers_always_on_position,
  input wire logic o_irq
);
  import dio_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic dir_wr;
  assign dir_wr = i_wr && i_addr == REG_DIR_CTRL && i_wdata[DIR_MODE_SET_BIT];
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_quiet; $rose(i_rst_n) |-> o_line_oe == 24'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("line driven after reset");
  property p_undriven; (o_line & ~o_line_oe) == 24'h0; endproperty
  a_undriven: assert property (p_undriven) else $error("level on undriven line");
  property p_a_in; dir_wr && i_wdata[DIR_A_BIT] |-> ##2 o_line_oe[7:0] == 8'h0; endproperty
  a_a_in: assert property (p_a_in) else $error("input port A driven");
  property p_b_in; dir_wr && i_wdata[DIR_B_BIT] |-> ##2 o_line_oe[15:8] == 8'h0; endproperty
  a_b_in: assert property (p_b_in) else $error("input port B driven");
  property p_c_hi_in; dir_wr && i_wdata[DIR_C_HI_BIT] |-> ##2 o_line_oe[23:20] == 4'h0; endproperty
  a_c_hi_in: assert property (p_c_hi_in) else $error("input upper C driven");
  // Jumper passes a synchroniser, so it must have been low a while
  property p_buf_off;
    !i_buffers_always_on_position [*3] ##0 (i_wr && i_addr == REG_BUF_CTRL && !i_wdata[BUF_EN_BIT])
      |-> ##2 o_line_oe == 24'h0;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffers on after disable");
  property p_mask_off; i_wr && i_addr == REG_IRQ_MASK && i_wdata[1:0] == 2'h0 |-> ##2 !o_irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  property p_rd_idle; !i_rd |=> o_rdata == 8'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unmapped; i_rd && i_addr > REG_CNT_RELOAD_HI |=> o_rdata == 8'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_steady; (!i_wr && $stable(i_buffers_always_on_position)) [*4] |-> $stable(o_line_oe); endproperty
  a_oe_steady: assert property (p_oe_steady) else $error("enables moved on their own");
  c_irq: cover property ($rose(o_irq));
  c_oe: cover property (o_line_oe != 24'h0);
  c_rd: cover property (i_rd && i_addr == REG_IRQ_STATUS);
endmodule // dio_port_props
bind dio_port dio_port_props dio_port_props_i (.*);

/* File: dio_field_model.sv */
// Purpose: field wiring with pull-ups in front of the port
// Assumes: bench overrides chosen lines
// Notes: contention is not modelled
`timescale 1ns/1ps
module dio_field_model (
  // Design side
  input wire logic [23:0] i_line_drv,
  input wire logic [23:0] i_line_oe,
  // Bench side
  input wire logic [23:0] i_ext_en,
  input wire logic [23:0] i_ext_val,
  // Wire level
  output logic [23:0] o_wire
);
  // Undriven lines rest high on pull-ups
  assign o_wire = (i_line_oe & i_line_drv) | (~i_line_oe & (~i_ext_en | i_ext_val));
endmodule // dio_field_model

/* File: dio_port_bench.sv */
// Purpose: self-checking bench for dio_port
// Assumes: 20 MHz clock
// Notes: one task per scenario
`timescale 1ns/1ps
module dio_port_bench;
  import dio_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, external_source_position = 1'b0, dis_n = 1'b1;
  logic ao = 1'b0, es = 1'b0, dj = 1'b1, tj = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [23:0] fen = 24'h0, fval = 24'h0, lvl, drv, oe;
  logic irq;
  int failures = 0, checks = 0, cyc = 0;
  always #25 clk = ~clk;
  dio_port dio_port_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_line(lvl), .o_line(drv), .o_line_oe(oe), .i_ext_irq(external_source_position),
    .i_irq_disable_n(dis_n), .i_buffers_always_on_position(ao), .i_external_source_position(es),
    .i_digital_irq_enable_jumper(dj), .i_timer_irq_enable_jumper(tj), .o_irq(irq));
  dio_field_model dio_field_model_i (.i_line_drv(drv), .i_line_oe(oe), .i_ext_en(fen),
    .i_ext_val(fval), .o_wire(lvl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data are valid only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    chk(oe, 24'h0);
    chk(lvl, 24'hffffff);
    chk(irq, 24'h0);
    wait_clk(4);
    rd_reg(REG_IRQ_STATUS, d);
    chk(d, 8'h00);
    $display("t_reset end");
  endtask
  task automatic t_dirs;
    logic [7:0] d;
    wr_reg(REG_BUF_CTRL, 8'h01);
    wr_reg(REG_DIR_CTRL, 8'h8a);
    wr_reg(REG_PORT_A, 8'ha5);
    wr_reg(REG_DIR_CTRL, 8'h05);
    wait_clk(2);
    chk(oe, 24'h0f00ff);
    chk(lvl[7:0], 8'ha5);
    chk(lvl[18], 1'b1);
    rd_reg(REG_PORT_A, d);
    chk(d, 8'ha5);
    rd_reg(4'hf, d);
    chk(d, 8'h00);
    wr_reg(REG_BUF_CTRL, 8'h00);
    wait_clk(2);
    chk(oe, 24'h0);
    ao <= 1'b1;
    wait_clk(6);
    chk(oe, 24'h0f00ff);
    $display("t_dirs end");
  endtask
  task automatic t_irq;
    logic [7:0] d;
    wr_reg(REG_DIR_CTRL, DIR_CTRL_RST);
    wr_reg(REG_IRQ_MASK, 8'h03);
    fen <= 24'h080000;
    wait_clk(8);
    wr_reg(REG_IRQ_STATUS, 8'h03);
    wait_clk(3);
    chk(irq, 1'b0);
    fval <= 24'h080000;
    wait_clk(8);
    chk(irq, 1'b1);
    wr_reg(REG_IRQ_STATUS, 8'h01);
    es <= 1'b1;
    wait_clk(6);
    external_source_position <= 1'b1;
    wait_clk(8);
    chk(irq, 1'b1);
    wr_reg(REG_IRQ_STATUS, 8'h01);
    external_source_position <= 1'b0;
    dis_n <= 1'b0;
    wait_clk(6);
    external_source_position <= 1'b1;
    wait_clk(8);
    chk(irq, 1'b0);
    rd_reg(REG_IRQ_STATUS, d);
    chk(d, 8'h00);
    dis_n <= 1'b1;
    $display("t_irq end");
  endtask
  task automatic t_timer;
    logic [7:0] d;
    wr_reg(REG_CNT_RELOAD_LO, 8'h03);
    wr_reg(REG_CNT_RELOAD_HI, 8'h00);
    tj <= 1'b1;
    wr_reg(REG_IRQ_STATUS, 8'h03);
    wait_clk(15);
    chk(irq, 1'b0);
    wait_clk(70);
    chk(irq, 1'b1);
    rd_reg(REG_IRQ_STATUS, d);
    chk(d[IRQ_TMR_BIT], 1'b1);
    wr_reg(REG_IRQ_MASK, 8'h00);
    wait_clk(2);
    chk(irq, 1'b0);
    $display("t_timer end");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_clk(1);
    t_reset();
    t_dirs();
    t_irq();
    t_timer();
    test_done();
  end
endmodule // dio_port_bench
